/* File: core/pmr_regs.svh */
// Offsets, field positions, reset values and timing counts of the monitor register bank.
// Assumes a 20 MHz core clock and pointer-addressed 16-bit registers.
`ifndef PMR_REGS_SVH
`define PMR_REGS_SVH

`define PMR_PTR_CONFIG   4'h0
`define PMR_PTR_STATUS   4'h1
`define PMR_PTR_MASK     4'h2
`define PMR_PTR_SHUNT    4'h3
`define PMR_PTR_BUS      4'h4
`define PMR_PTR_POWER    4'h5
`define PMR_PTR_CURRENT  4'h6
`define PMR_PTR_SHMAX    4'h7
`define PMR_PTR_SHMIN    4'h8
`define PMR_PTR_BUSMAX   4'h9
`define PMR_PTR_BUSMIN   4'hA
`define PMR_PTR_PWRMAX   4'hB
`define PMR_PTR_SHPOSLIM 4'hC
`define PMR_PTR_SHNEGLIM 4'hD
`define PMR_PTR_PWRLIM   4'hE
`define PMR_PTR_BUSHILIM 4'hF

`define PMR_RST_CONFIG   16'h399F
`define PMR_RST_SHMAX    16'h8000
`define PMR_RST_SHMIN    16'h7FFF
`define PMR_RST_BUSMIN   16'hFFF8
`define PMR_RST_ZERO     16'h0000

`define PMR_CFG_RESET_BIT 15
`define PMR_ST_WOV        15
`define PMR_ST_WP         13
`define PMR_ST_WSP        12
`define PMR_ST_WSN        11
`define PMR_ST_CNVR       5
`define PMR_ST_SMBA       4
`define PMR_ST_OVF        3
`define PMR_BHL_POL_BIT   0
`define PMR_BHL_LATCH_BIT 1

`define PMR_UPDATE_NS    4000
`define PMR_CLK_MHZ      20
`define PMR_UPDATE_CYC   ((`PMR_UPDATE_NS * `PMR_CLK_MHZ) / 1000)

`endif

/* File: core/pmr_pkg.sv */
// Types shared by the monitor register bank.
// Assumes the constants of pmr_regs.svh for offsets and values.
`default_nettype none

package pmr_pkg;

   typedef struct packed {
      logic [15:0] shunt;
      logic [15:0] bus;
      logic [15:0] power;
      logic [15:0] current;
   } pmr_meas_t;

   typedef enum logic [0:0] {
      PMR_PH_HI = 1'b0,
      PMR_PH_LO = 1'b1
   } pmr_phase_t;

endpackage

`default_nettype wire

/* File: core/pmr_bank.sv */
// Pointer-addressed register bank of a current, voltage and power monitor.
// Assumes a serial byte engine on the same clock hands over pointer and data bytes.
// What this block does
// - Written contents take effect and read back within 4 us of write end.
// - Configuration at pointer 00 is read/write and resets to 399F.
// - Status at pointer 01 is read-only, resets to zero, reports flags.
// - Alert mask at pointer 02 is read/write, resets zero, gates alert.
// - Result registers at pointers 03 to 06 are read-only, reset to zero.
// - Current result stays zero until a nonzero calibration exists.
// - Pointer 07 tracks the most positive shunt result, resets 8000.
// - Pointer 08 tracks the most negative shunt result, resets 7FFF.
// - Pointer 09 tracks the highest bus result, resets zero.
// - Pointer 0A tracks the lowest bus result, resets FFF8.
// - Pointer 0B tracks the highest power result, resets zero.
// - Shunt above limit at 0C sets warning flag and warning pin.
// - Shunt below limit at 0D sets warning flag and warning pin.
// - Power above limit at 0E sets warning flag and warning pin.
// - Pointer 0F holds bus high limit plus pin polarity and latch bits.
// - Registers are 16 bits, moved as two bytes, high byte first.
// - Reading status clears flags; still-violated flags set again at once.
// - Writing configuration bit 15 restores all registers; bit self-clears.
`include "pmr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pmr_bank (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Byte engine side
   input wire logic ptr_valid,
   input wire logic wr_byte_valid,
   input wire logic rd_byte_req,
   input wire logic xfer_stop,
   input wire logic [7:0] wr_byte,
   output logic [7:0] rd_byte_q,
   output logic rd_valid_q,
   // Measurement side
   input wire logic meas_valid,
   input wire pmr_pkg::pmr_meas_t meas,
   input wire logic calib_nonzero,
   input wire logic ovf_event,
   // Control and pins
   output logic [15:0] config_q,
   output logic warn_pin_q,
   output logic alert_q
);

   logic [15:0] reg_q [0:15];
   logic [15:0] reg_d [0:15];
   logic [15:0] status_q;
   logic [15:0] status_d;
   logic [7:0] ptr_q;
   logic [7:0] wr_hi_q;
   logic [7:0] rd_lo_q;
   pmr_pkg::pmr_phase_t phase_q;
   pmr_pkg::pmr_phase_t phase_d;

   function automatic logic [15:0] rst_val(input logic [3:0] idx);
      case (idx)
         `PMR_PTR_CONFIG: rst_val = `PMR_RST_CONFIG;
         `PMR_PTR_SHMAX: rst_val = `PMR_RST_SHMAX;
         `PMR_PTR_SHMIN: rst_val = `PMR_RST_SHMIN;
         `PMR_PTR_BUSMIN: rst_val = `PMR_RST_BUSMIN;
         default: rst_val = `PMR_RST_ZERO;
      endcase
   endfunction

   // Byte framing and pointer decode
   wire ptr_in_bank = (ptr_q[7:4] == 4'h0);
   wire [3:0] ptr_idx = ptr_q[3:0];
   wire is_hi = (phase_q == pmr_pkg::PMR_PH_HI);
   wire wr_commit = wr_byte_valid && !is_hi;
   wire [15:0] wr_word = {wr_hi_q, wr_byte};
   wire ptr_ro = (ptr_idx == `PMR_PTR_STATUS) || ((ptr_idx >= `PMR_PTR_SHUNT)
                 && (ptr_idx <= `PMR_PTR_CURRENT));
   wire wr_ok = wr_commit && ptr_in_bank && !ptr_ro;
   // Reset bit rides in the high byte, so it is taken from the assembled word
   wire soft_rst = wr_ok && (ptr_idx == `PMR_PTR_CONFIG) && wr_word[`PMR_CFG_RESET_BIT];
   wire rd_status = rd_byte_req && is_hi && ptr_in_bank && (ptr_idx == `PMR_PTR_STATUS);

   // Read word is taken live, so a readback right after a write sees the new value
   wire [15:0] rd_word = !ptr_in_bank ? 16'h0000 :
                         (ptr_idx == `PMR_PTR_STATUS) ? status_q : reg_q[ptr_idx];

   // Limit comparisons against the live results
   wire [15:0] bhl = reg_q[`PMR_PTR_BUSHILIM];
   wire pin_pol = bhl[`PMR_BHL_POL_BIT];
   wire latch_en = bhl[`PMR_BHL_LATCH_BIT];
   wire cond_wov = reg_q[`PMR_PTR_BUS][15:3] > bhl[15:3];
   wire cond_wp = reg_q[`PMR_PTR_POWER] > reg_q[`PMR_PTR_PWRLIM];
   wire cond_wsp = $signed(reg_q[`PMR_PTR_SHUNT]) > $signed(reg_q[`PMR_PTR_SHPOSLIM]);
   wire cond_wsn = $signed(reg_q[`PMR_PTR_SHUNT]) < $signed(reg_q[`PMR_PTR_SHNEGLIM]);
   wire warn_any = |status_q[`PMR_ST_WOV:`PMR_ST_WSN];

   wire [15:0] sh_new = meas.shunt;
   wire [15:0] bus_new = meas.bus;
   wire [15:0] pwr_new = meas.power;
   wire [15:0] cur_new = calib_nonzero ? meas.current : 16'h0000;

   always_comb begin
      for (int i = 0; i < 16; i++) begin
         reg_d[i] = reg_q[i];
      end
      reg_d[`PMR_PTR_STATUS] = `PMR_RST_ZERO;
      if (meas_valid) begin
         reg_d[`PMR_PTR_SHUNT] = sh_new;
         reg_d[`PMR_PTR_BUS] = bus_new;
         reg_d[`PMR_PTR_POWER] = pwr_new;
         reg_d[`PMR_PTR_CURRENT] = cur_new;
         if ($signed(sh_new) > $signed(reg_q[`PMR_PTR_SHMAX])) begin
            reg_d[`PMR_PTR_SHMAX] = sh_new;
         end
         if ($signed(sh_new) < $signed(reg_q[`PMR_PTR_SHMIN])) begin
            reg_d[`PMR_PTR_SHMIN] = sh_new;
         end
         if (bus_new > reg_q[`PMR_PTR_BUSMAX]) begin
            reg_d[`PMR_PTR_BUSMAX] = bus_new;
         end
         if (bus_new < reg_q[`PMR_PTR_BUSMIN]) begin
            reg_d[`PMR_PTR_BUSMIN] = bus_new;
         end
         if (pwr_new > reg_q[`PMR_PTR_PWRMAX]) begin
            reg_d[`PMR_PTR_PWRMAX] = pwr_new;
         end
      end
      // A host write beats a peak update in the same cycle; the reset bit is never stored
      if (wr_ok) begin
         reg_d[ptr_idx] = wr_word;
         if (ptr_idx == `PMR_PTR_CONFIG) begin
            reg_d[ptr_idx][`PMR_CFG_RESET_BIT] = 1'b0;
         end
      end
      if (soft_rst) begin
         for (int i = 0; i < 16; i++) begin
            reg_d[i] = rst_val(4'(i));
         end
      end
   end

   // Status flags: a set in the clearing cycle wins
   wire st_clr = rd_status;
   wire [15:0] st_cond = {cond_wov, 1'b0, cond_wp, cond_wsp, cond_wsn, 11'h000};
   wire [15:0] st_hold = latch_en ? status_q : 16'h0000;
   wire [15:0] warn_next = st_cond | (st_hold & ~{16{st_clr}});
   wire [15:0] ev_set = {10'h000, meas_valid, 1'b0, ovf_event, 3'h0};
   wire [15:0] ev_next = ev_set | (status_q & ~{16{st_clr}});
   wire [15:0] mask_q = reg_q[`PMR_PTR_MASK];
   wire [15:0] flags_next = (warn_next & 16'hF800) | (ev_next & 16'h0028);
   wire alert_set = |(flags_next & ~mask_q & 16'hF828);
   wire smba_next = alert_set || (status_q[`PMR_ST_SMBA] && !st_clr);

   always_comb begin
      status_d = flags_next;
      status_d[`PMR_ST_SMBA] = smba_next;
      if (soft_rst) begin
         status_d = `PMR_RST_ZERO;
      end
   end

   always_comb begin
      phase_d = phase_q;
      if (ptr_valid || xfer_stop) begin
         phase_d = pmr_pkg::PMR_PH_HI;
      end else if (wr_byte_valid || rd_byte_req) begin
         case (phase_q)
            pmr_pkg::PMR_PH_HI: phase_d = pmr_pkg::PMR_PH_LO;
            pmr_pkg::PMR_PH_LO: phase_d = pmr_pkg::PMR_PH_HI;
            default: phase_d = pmr_pkg::PMR_PH_HI;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      for (int i = 0; i < 16; i++) begin
         reg_q[i] <= reset ? rst_val(4'(i)) : reg_d[i];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         status_q <= `PMR_RST_ZERO;
         phase_q <= pmr_pkg::PMR_PH_HI;
         ptr_q <= 8'h00;
         wr_hi_q <= 8'h00;
         rd_lo_q <= 8'h00;
      end else begin
         status_q <= status_d;
         phase_q <= phase_d;
         if (ptr_valid) begin
            ptr_q <= wr_byte;
         end
         if (wr_byte_valid && is_hi && !ptr_valid) begin
            wr_hi_q <= wr_byte;
         end
         if (rd_byte_req && is_hi) begin
            rd_lo_q <= rd_word[7:0];
         end
      end
   end

   // Low byte comes from the snapshot so both halves of one word match
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_byte_q <= 8'h00;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_byte_req;
         if (rd_byte_req) begin
            rd_byte_q <= is_hi ? rd_word[15:8] : rd_lo_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         config_q <= `PMR_RST_CONFIG;
         warn_pin_q <= 1'b1;
         alert_q <= 1'b0;
      end else begin
         config_q <= reg_d[`PMR_PTR_CONFIG];
         warn_pin_q <= pin_pol ? warn_any : !warn_any;
         alert_q <= status_d[`PMR_ST_SMBA];
      end
   end

   localparam int UPD_CYC = `PMR_UPDATE_CYC;

   write_commit_a: assert property (@(posedge clk) disable iff (reset)
      (wr_ok && !soft_rst && ptr_idx != `PMR_PTR_CONFIG) |=>
      reg_q[$past(ptr_idx)] == $past(wr_word))
      else $error("written register did not take the new value");

   write_readback_a: assert property (@(posedge clk) disable iff (reset)
      (wr_ok && ptr_idx == `PMR_PTR_MASK) ##1 (rd_byte_req && is_hi && !ptr_valid
      && !wr_byte_valid)[*1] |=> rd_byte_q == $past(wr_word[15:8], 2))
      else $error("readback after write returned stale data");

   cfg_reset_a: assert property (@(posedge clk) reset |=> config_q == `PMR_RST_CONFIG)
      else $error("configuration reset value wrong");

   ro_write_a: assert property (@(posedge clk) disable iff (reset)
      (wr_commit && ptr_ro && !meas_valid && !soft_rst) |=> $stable(reg_q[`PMR_PTR_POWER]))
      else $error("read-only result changed on a write");

   current_zero_a: assert property (@(posedge clk) disable iff (reset)
      (meas_valid && !calib_nonzero) |=> reg_q[`PMR_PTR_CURRENT] == 16'h0000)
      else $error("current nonzero without calibration");

   shunt_peak_a: assert property (@(posedge clk) disable iff (reset)
      (meas_valid && !wr_ok && $signed(sh_new) > $signed(reg_q[`PMR_PTR_SHMAX])) |=>
      reg_q[`PMR_PTR_SHMAX] == $past(sh_new))
      else $error("positive shunt peak not tracked");

   bus_low_a: assert property (@(posedge clk) disable iff (reset)
      (meas_valid && !wr_ok && bus_new < reg_q[`PMR_PTR_BUSMIN]) |=>
      reg_q[`PMR_PTR_BUSMIN] == $past(bus_new))
      else $error("bus minimum peak not tracked");

   soft_reset_a: assert property (@(posedge clk) disable iff (reset)
      soft_rst |=> (reg_q[`PMR_PTR_SHMIN] == `PMR_RST_SHMIN && config_q == `PMR_RST_CONFIG
      && status_q == 16'h0000))
      else $error("soft reset did not restore defaults");

   status_clear_a: assert property (@(posedge clk) disable iff (reset)
      (st_clr && !meas_valid && !ovf_event) |=> !status_q[`PMR_ST_CNVR] && !status_q[`PMR_ST_OVF])
      else $error("status read did not clear event flags");

   power_warn_a: assert property (@(posedge clk) disable iff (reset)
      (cond_wp && !soft_rst) |=> status_q[`PMR_ST_WP] ##1 (warn_pin_q == $past(pin_pol)))
      else $error("power warning flag or pin missing");

   shunt_warn_a: assert property (@(posedge clk) disable iff (reset)
      (cond_wsp && !soft_rst) |=> status_q[`PMR_ST_WSP])
      else $error("shunt positive warning flag missing");

   // Peak checks skip write cycles, where the host write wins over tracking
   shunt_low_a: assert property (@(posedge clk) disable iff (reset)
      (meas_valid && !wr_ok && $signed(sh_new) < $signed(reg_q[`PMR_PTR_SHMIN])) |=>
      reg_q[`PMR_PTR_SHMIN] == $past(sh_new))
      else $error("negative shunt peak not tracked");

   bus_high_a: assert property (@(posedge clk) disable iff (reset)
      (meas_valid && !wr_ok && bus_new > reg_q[`PMR_PTR_BUSMAX]) |=>
      reg_q[`PMR_PTR_BUSMAX] == $past(bus_new))
      else $error("bus maximum peak not tracked");

   power_peak_a: assert property (@(posedge clk) disable iff (reset)
      (meas_valid && !wr_ok && pwr_new > reg_q[`PMR_PTR_PWRMAX]) |=>
      reg_q[`PMR_PTR_PWRMAX] == $past(pwr_new))
      else $error("power peak not tracked");

   result_update_a: assert property (@(posedge clk) disable iff (reset)
      (meas_valid && !soft_rst) |=> (reg_q[`PMR_PTR_SHUNT] == $past(sh_new)
      && reg_q[`PMR_PTR_BUS] == $past(bus_new) && reg_q[`PMR_PTR_POWER] == $past(pwr_new)))
      else $error("result registers did not follow the conversion");

   status_reset_a: assert property (@(posedge clk) reset |=> status_q == 16'h0000)
      else $error("status reset value wrong");

   shunt_neg_warn_a: assert property (@(posedge clk) disable iff (reset)
      (cond_wsn && !soft_rst) |=> status_q[`PMR_ST_WSN])
      else $error("shunt negative warning flag missing");

   bus_warn_a: assert property (@(posedge clk) disable iff (reset)
      (cond_wov && !soft_rst) |=> status_q[`PMR_ST_WOV])
      else $error("bus over-voltage warning flag missing");

   warn_latch_a: assert property (@(posedge clk) disable iff (reset)
      (latch_en && status_q[`PMR_ST_WOV] && !st_clr && !soft_rst) |=> status_q[`PMR_ST_WOV])
      else $error("latched warning flag lost without a status read");

   alert_mask_a: assert property (@(posedge clk) disable iff (reset)
      ((mask_q & 16'hF828) == 16'hF828 && !status_q[`PMR_ST_SMBA]) |=> !alert_q)
      else $error("alert raised although every flag is masked");

   pin_level_a: assert property (@(posedge clk) disable iff (reset)
      (warn_any && pin_pol) |=> warn_pin_q)
      else $error("active-high warning pin not driven");

   ptr_load_a: assert property (@(posedge clk) disable iff (reset)
      ptr_valid |=> ptr_q == $past(wr_byte))
      else $error("pointer byte not loaded");

   update_time_c: cover property (@(posedge clk) disable iff (reset)
      wr_ok ##[1:UPD_CYC] rd_byte_req);
   soft_reset_c: cover property (@(posedge clk) disable iff (reset) soft_rst);
   status_read_c: cover property (@(posedge clk) disable iff (reset)
      st_clr && |status_q);
   warn_pin_c: cover property (@(posedge clk) disable iff (reset) $fell(warn_pin_q));
   warn_latch_c: cover property (@(posedge clk) disable iff (reset)
      latch_en && warn_any && st_clr);

endmodule

`default_nettype wire

/* File: sim/pmr_host_model.sv */
// Host-side byte engine model: pointer, write and read strobes toward the bank.
// Assumes the bank samples on the rising edge; this model moves on falling edges.
`include "pmr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pmr_host_model (
   // Clock
   input wire logic clk,
   // Strobes and byte toward the bank
   output logic ptr_valid,
   output logic wr_byte_valid,
   output logic rd_byte_req,
   output logic xfer_stop,
   output logic [7:0] wr_byte,
   // Read return
   input wire logic [7:0] rd_byte_q,
   input wire logic rd_valid_q
);
   initial begin
      ptr_valid = 1'b0;
      wr_byte_valid = 1'b0;
      rd_byte_req = 1'b0;
      xfer_stop = 1'b0;
      wr_byte = 8'h00;
   end

   // Idle byte is the inverse of the last one so stale data never looks valid
   task write_reg(input logic [7:0] p, input logic [15:0] d);
      @(negedge clk);
      ptr_valid = 1'b1;
      wr_byte = p;
      @(negedge clk);
      ptr_valid = 1'b0;
      wr_byte_valid = 1'b1;
      wr_byte = d[15:8];
      @(negedge clk);
      wr_byte = d[7:0];
      @(negedge clk);
      wr_byte_valid = 1'b0;
      xfer_stop = 1'b1;
      wr_byte = ~d[7:0];
      @(negedge clk);
      xfer_stop = 1'b0;
      // Settling wait kept even below 1 MHz, so every read-back tests the 4 us bound
      repeat (`PMR_UPDATE_CYC) @(negedge clk);
   endtask

   task get_byte(output logic [7:0] b);
      int n;
      b = 8'hXX;
      n = 0;
      rd_byte_req = 1'b1;
      @(negedge clk);
      rd_byte_req = 1'b0;
      while (rd_valid_q !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      if (rd_valid_q === 1'b1) begin
         b = rd_byte_q;
      end
   endtask

   task read_reg(input logic [7:0] p, output logic [15:0] d);
      @(negedge clk);
      ptr_valid = 1'b1;
      wr_byte = p;
      @(negedge clk);
      ptr_valid = 1'b0;
      wr_byte = ~p;
      get_byte(d[15:8]);
      // One idle edge so the request strobe is never lowered and raised in one step
      @(negedge clk);
      get_byte(d[7:0]);
      xfer_stop = 1'b1;
      @(negedge clk);
      xfer_stop = 1'b0;
   endtask

   // Write, then read back at once with no stop and no new pointer
   // Legal only while the serial clock stays at or below 1 MHz
   task write_rd(input logic [7:0] p, input logic [15:0] d, output logic [15:0] q);
      @(negedge clk);
      ptr_valid = 1'b1;
      wr_byte = p;
      @(negedge clk);
      ptr_valid = 1'b0;
      wr_byte_valid = 1'b1;
      wr_byte = d[15:8];
      @(negedge clk);
      wr_byte = d[7:0];
      @(negedge clk);
      wr_byte_valid = 1'b0;
      wr_byte = ~d[7:0];
      get_byte(q[15:8]);
      @(negedge clk);
      get_byte(q[7:0]);
      xfer_stop = 1'b1;
      @(negedge clk);
      xfer_stop = 1'b0;
   endtask
endmodule

`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the monitor register bank with a reference register image.
// Assumes the host model for all register traffic; measurements driven here.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic meas_valid = 1'b0, calib_nonzero = 1'b0, ovf_event = 1'b0, cal;
   logic ptr_valid, wr_byte_valid, rd_byte_req, xfer_stop, rd_valid_q, warn_pin_q, alert_q;
   logic [7:0] wr_byte, rd_byte_q;
   logic [15:0] config_q, d, s, b, pw, cu;
   pmr_pkg::pmr_meas_t meas = '0;
   logic [15:0] exp_q [16];
   logic [15:0] rst_tab [16] = '{16'h399F, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h8000, 16'h7FFF, 16'h0000, 16'hFFF8, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000};
   logic [15:0] vs [4] = '{16'h1001, 16'hEFFF, 16'h0000, 16'h0000};
   logic [15:0] vb [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h4008};
   logic [15:0] vp [4] = '{16'h0000, 16'h0000, 16'h2001, 16'h0000};
   logic [15:0] vf [4] = '{16'h1000, 16'h0800, 16'h2000, 16'h8000};
   int err_count = 0, num_checks = 0, i, n, seed;

   always #25 clk = ~clk;

   pmr_bank pmr_bank_i (.clk(clk), .reset(reset), .ptr_valid(ptr_valid),
      .wr_byte_valid(wr_byte_valid), .rd_byte_req(rd_byte_req), .xfer_stop(xfer_stop),
      .wr_byte(wr_byte), .rd_byte_q(rd_byte_q), .rd_valid_q(rd_valid_q),
      .meas_valid(meas_valid), .meas(meas), .calib_nonzero(calib_nonzero),
      .ovf_event(ovf_event), .config_q(config_q), .warn_pin_q(warn_pin_q), .alert_q(alert_q));

   pmr_host_model pmr_host_model_i (.clk(clk), .ptr_valid(ptr_valid),
      .wr_byte_valid(wr_byte_valid), .rd_byte_req(rd_byte_req), .xfer_stop(xfer_stop),
      .wr_byte(wr_byte), .rd_byte_q(rd_byte_q), .rd_valid_q(rd_valid_q));

   task check(input logic [15:0] seen, input logic [15:0] want);
      num_checks++;
      if (seen !== want) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task rd_chk(input logic [7:0] p, input logic [15:0] want);
      logic [15:0] v;
      pmr_host_model_i.read_reg(p, v);
      check(v, want);
   endtask

   task send_meas(input logic [15:0] ms, mb, mp, mc, input logic mcal, mov);
      @(negedge clk);
      meas = {ms, mb, mp, mc};
      calib_nonzero = mcal;
      meas_valid = 1'b1;
      ovf_event = mov;
      @(negedge clk);
      meas_valid = 1'b0;
      ovf_event = 1'b0;
      repeat (4) @(negedge clk);
   endtask

   task close_out;
      if (err_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      close_out();
   end

   initial begin
      seed = 32'hafeaf93f;
      exp_q = rst_tab;
      repeat (10) @(negedge clk);
      reset = 1'b0;
      for (i = 0; i < 16; i++) rd_chk(i[7:0], exp_q[i]);
      rd_chk(8'h13, 16'h0000);
      check({14'h0, alert_q, warn_pin_q}, 16'h0001);
      // Random data to every pointer; read-only ones must keep their value
      for (i = 0; i < 16; i++) begin
         d = 16'($random(seed));
         if (i == 0) d[15] = 1'b0;
         pmr_host_model_i.write_reg(i[7:0], d);
         if (!(i inside {1, 3, 4, 5, 6})) exp_q[i] = d;
         rd_chk(i[7:0], exp_q[i]);
      end
      check(config_q, exp_q[0]);
      pmr_host_model_i.write_reg(8'h00, 16'h8000);
      exp_q = rst_tab;
      for (i = 0; i < 16; i++) rd_chk(i[7:0], exp_q[i]);
      check(config_q, 16'h399F);
      // Results follow each conversion; peaks follow their extremes
      for (n = 0; n < 12; n++) begin
         s = 16'($random(seed));
         b = 16'($random(seed));
         pw = 16'($random(seed));
         cu = 16'($random(seed));
         cal = n[0];
         send_meas(s, b, pw, cu, cal, 1'b0);
         exp_q[3] = s;
         exp_q[4] = b;
         exp_q[5] = pw;
         exp_q[6] = cal ? cu : 16'h0000;
         if ($signed(s) > $signed(exp_q[7])) exp_q[7] = s;
         if ($signed(s) < $signed(exp_q[8])) exp_q[8] = s;
         if (b > exp_q[9]) exp_q[9] = b;
         if (b < exp_q[10]) exp_q[10] = b;
         if (pw > exp_q[11]) exp_q[11] = pw;
         for (i = 3; i < 12; i++) rd_chk(i[7:0], exp_q[i]);
      end
      pmr_host_model_i.write_reg(8'h00, 16'h8000);
      pmr_host_model_i.write_reg(8'h0C, 16'h1000);
      pmr_host_model_i.write_reg(8'h0D, 16'hF000);
      pmr_host_model_i.write_reg(8'h0E, 16'h2000);
      pmr_host_model_i.write_reg(8'h0F, 16'h4000);
      rd_chk(8'h01, 16'h0000);
      // One limit violated at a time, then a clean conversion with an overflow event
      for (i = 0; i < 4; i++) begin
         send_meas(vs[i], vb[i], vp[i], 16'h0000, 1'b0, 1'b0);
         check({14'h0, alert_q, warn_pin_q}, 16'h0002);
         rd_chk(8'h01, vf[i] | 16'h0030);
         repeat (4) @(negedge clk);
         rd_chk(8'h01, vf[i] | 16'h0010);
         send_meas(16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b1);
         rd_chk(8'h01, 16'h0038);
         check({14'h0, alert_q, warn_pin_q}, 16'h0001);
         rd_chk(8'h01, 16'h0000);
      end
      // Alerts masked off, warning latched, pin active high
      pmr_host_model_i.write_rd(8'h02, 16'hF828, d);
      check(d, 16'hF828);
      pmr_host_model_i.write_reg(8'h0F, 16'h4003);
      send_meas(16'h0000, 16'h4008, 16'h0000, 16'h0000, 1'b0, 1'b0);
      check({14'h0, alert_q, warn_pin_q}, 16'h0001);
      send_meas(16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
      rd_chk(8'h01, 16'h8020);
      rd_chk(8'h01, 16'h0000);
      check({14'h0, alert_q, warn_pin_q}, 16'h0000);
      close_out();
   end
endmodule

`default_nettype wire
